//--- inc/sto_pkg.sv
// Functional notes
// [RULE1] Two-bit swing code selects 1, 2/3, 7/3 or 5/3 of nominal swing.
// [RULE2] Two-bit current code selects 1, 2/3, 1/2 or 2/5 of nominal current.
// [RULE3] Input bit set routes the shared strength/IF pin into the IF strip.
// [RULE4] Front bit set routes front amplifier output onto the shared pin.
// [RULE5] Test point selects join pump output node; both clear grounds it.
// [RULE6] Override bit applies five-bit pump current value, reset 10000.
// [RULE7] Pump disable bit suppresses every pump up and down pulse.
// [RULE8] Array override bit applies four-bit array value, reset 1000.
// [RULE9] Software sets bandwidth constant to 3Fh at 9.6 kBaud up; reset 100101.
// [RULE10] Loop break opens the loop and applies DAC override, reset 0100.
// [RULE11] Read-only field shows pump current actually applied.
// [RULE12] Read-only field shows calibration DAC value applied.
// [RULE13] Read-only field shows oscillator array value applied.
// [RULE14] Unused bits ignore writes, read zero; status writes have no effect.
`default_nettype none
package sto_pkg;
   // ==========================================================
   // Register addresses (seven-bit serial address space)
   localparam logic [6:0] STO_ADDR_PRESCALER_SETTINGS = 7'h1C;
   localparam logic [6:0] STO_ADDR_TEST_LF_PUMP_OVR = 7'h40;
   localparam logic [6:0] STO_ADDR_TEST_PUMP_DIS_OSC_OVR = 7'h41;
   localparam logic [6:0] STO_ADDR_TEST_LOOP_BW_SCALING = 7'h42;
   localparam logic [6:0] STO_ADDR_TEST_LOOP_BREAK_DAC = 7'h43;
   localparam logic [6:0] STO_ADDR_STATUS_PUMP_CURRENT = 7'h44;
   localparam logic [6:0] STO_ADDR_STATUS_CAL_DAC = 7'h45;
   localparam logic [6:0] STO_ADDR_STATUS_OSC_ARRAY = 7'h46;
   // ==========================================================
   // Implemented-bit masks; other bits stay zero
   localparam logic [7:0] STO_MASK_PRESCALER = 8'hFC;
   localparam logic [7:0] STO_MASK_LF_PUMP = 8'hFF;
   localparam logic [7:0] STO_MASK_DIS_OSC = 8'h3F;
   localparam logic [7:0] STO_MASK_BW = 8'h3F;
   localparam logic [7:0] STO_MASK_BREAK = 8'h1F;
   // ==========================================================
   // Reset values
   localparam logic [7:0] STO_RST_PRESCALER = 8'h00;
   localparam logic [7:0] STO_RST_LF_PUMP = 8'h10;
   localparam logic [7:0] STO_RST_DIS_OSC = 8'h08;
   localparam logic [7:0] STO_RST_BW = 8'h25; // [RULE9]
   localparam logic [7:0] STO_RST_BREAK = 8'h04;
   // ==========================================================
   // Field positions
   localparam int STO_SWING_LSB = 6;
   localparam int STO_CURRENT_LSB = 4;
   localparam int STO_IF_INPUT_BIT = 3;
   localparam int STO_IF_FRONT_BIT = 2;
   localparam int STO_TP_A_BIT = 7;
   localparam int STO_TP_B_BIT = 6;
   localparam int STO_PUMP_OVR_BIT = 5;
   localparam int STO_PUMP_DIS_BIT = 5;
   localparam int STO_OSC_OVR_BIT = 4;
   localparam int STO_BREAK_BIT = 4;
   // ==========================================================
   // Serial frame
   localparam logic [3:0] STO_LAST_BIT = 4'h7;
   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      SER_IDLE,
      SER_ADDR,
      SER_GAP,
      SER_WDATA,
      SER_RDATA
   } sto_ser_state_t;
   typedef struct packed {
      logic [7:0] prescaler_settings;
      logic [7:0] test_loopfilter_chargepump_override;
      logic [7:0] test_chargepump_disable_osc_array_override_en;
      logic [7:0] test_loop_bandwidth_scaling;
      logic [7:0] test_loop_break_cal_dac;
   } sto_cfg_t;
   localparam sto_cfg_t STO_CFG_RESET = '{
      prescaler_settings: STO_RST_PRESCALER,
      test_loopfilter_chargepump_override: STO_RST_LF_PUMP,
      test_chargepump_disable_osc_array_override_en: STO_RST_DIS_OSC,
      test_loop_bandwidth_scaling: STO_RST_BW,
      test_loop_break_cal_dac: STO_RST_BREAK};
   typedef struct packed {
      logic [4:0] pump_current;
      logic [3:0] cal_dac;
      logic [3:0] osc_array;
   } sto_cal_t;
   typedef struct packed {
      logic [2:0] num;
      logic [2:0] den;
   } sto_frac_t;
   typedef struct packed {
      logic [1:0] swing_code;
      sto_frac_t swing;
      logic [1:0] current_code;
      sto_frac_t current;
      logic if_strip_from_pin;
      logic if_front_to_pin;
      logic loop_testpoint_a_sel;
      logic loop_testpoint_b_sel;
      logic pump_output_node_grounded;
      logic [4:0] applied_pump_current;
      logic pump_pulse_disable;
      logic [3:0] applied_osc_array;
      logic [5:0] loop_bandwidth_scaling;
      logic loop_open;
      logic [3:0] applied_cal_dac;
   } sto_ctrl_t;
   typedef struct packed {
      sto_ser_state_t st;
      logic clk_d;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [6:0] addr;
      logic wr;
      logic oe;
      sto_cfg_t cfg;
   } sto_ser_s_t;
   localparam sto_ser_s_t STO_SER_RESET = '{
      st: SER_IDLE, clk_d: 1'b0, cnt: 4'h0, sh: 8'h00, addr: 7'h00,
      wr: 1'b0, oe: 1'b0, cfg: STO_CFG_RESET};
   // ==========================================================
   // Fraction decoders
   function automatic sto_frac_t sto_swing_frac(input logic [1:0] code);
      sto_frac_t f;
      unique case (code)
         2'h0: f = '{num: 3'h1, den: 3'h1};
         2'h1: f = '{num: 3'h2, den: 3'h3};
         2'h2: f = '{num: 3'h7, den: 3'h3};
         2'h3: f = '{num: 3'h5, den: 3'h3};
      endcase
      return f;
   endfunction
   function automatic sto_frac_t sto_current_frac(input logic [1:0] code);
      sto_frac_t f;
      unique case (code)
         2'h0: f = '{num: 3'h1, den: 3'h1};
         2'h1: f = '{num: 3'h2, den: 3'h3};
         2'h2: f = '{num: 3'h1, den: 3'h2};
         2'h3: f = '{num: 3'h2, den: 3'h5};
      endcase
      return f;
   endfunction
endpackage
`default_nettype wire

//--- logic/sto_apply_sel.sv
`default_nettype none
module sto_apply_sel (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire sto_pkg::sto_cfg_t cfg_i,
   input wire sto_pkg::sto_cal_t cal_i,
   input wire logic pump_up_i,
   input wire logic pump_dn_i,
   output var sto_pkg::sto_ctrl_t ctrl_o,
   output logic pump_up_o,
   output logic pump_dn_o
);
   import sto_pkg::*;

   typedef struct packed {
      sto_ctrl_t ctrl;
      logic up;
      logic dn;
   } sto_sel_s_t;

   sto_sel_s_t s_r;
   sto_sel_s_t s_nxt;
   logic [7:0] pre;
   logic [7:0] lfp;
   logic [7:0] dso;
   logic [7:0] brk;

   // ==========================================================
   // Analog control selection
   assign pre = cfg_i.prescaler_settings;
   assign lfp = cfg_i.test_loopfilter_chargepump_override;
   assign dso = cfg_i.test_chargepump_disable_osc_array_override_en;
   assign brk = cfg_i.test_loop_break_cal_dac;

   // Everything is registered so the analog side sees glitch-free levels
   always_comb begin
      s_nxt = s_r;
      s_nxt.ctrl.swing_code = pre[STO_SWING_LSB+:2]; // [RULE1]
      s_nxt.ctrl.swing = sto_swing_frac(pre[STO_SWING_LSB+:2]); // [RULE1]
      s_nxt.ctrl.current_code = pre[STO_CURRENT_LSB+:2]; // [RULE2]
      s_nxt.ctrl.current = sto_current_frac(pre[STO_CURRENT_LSB+:2]); // [RULE2]
      s_nxt.ctrl.if_strip_from_pin = pre[STO_IF_INPUT_BIT]; // [RULE3]
      s_nxt.ctrl.if_front_to_pin = pre[STO_IF_FRONT_BIT]; // [RULE4]
      s_nxt.ctrl.loop_testpoint_a_sel = lfp[STO_TP_A_BIT]; // [RULE5]
      s_nxt.ctrl.loop_testpoint_b_sel = lfp[STO_TP_B_BIT]; // [RULE5]
      // Node is grounded only while no test point is attached
      s_nxt.ctrl.pump_output_node_grounded =
         ~lfp[STO_TP_A_BIT] & ~lfp[STO_TP_B_BIT]; // [RULE5]
      s_nxt.ctrl.applied_pump_current = lfp[STO_PUMP_OVR_BIT] ?
         lfp[4:0] : cal_i.pump_current; // [RULE6]
      s_nxt.ctrl.pump_pulse_disable = dso[STO_PUMP_DIS_BIT]; // [RULE7]
      s_nxt.ctrl.applied_osc_array = dso[STO_OSC_OVR_BIT] ?
         dso[3:0] : cal_i.osc_array; // [RULE8]
      s_nxt.ctrl.loop_bandwidth_scaling =
         cfg_i.test_loop_bandwidth_scaling[5:0];
      s_nxt.ctrl.loop_open = brk[STO_BREAK_BIT]; // [RULE10]
      s_nxt.ctrl.applied_cal_dac = brk[STO_BREAK_BIT] ?
         brk[3:0] : cal_i.cal_dac; // [RULE10]
      // Pulses cost one cycle of latency in exchange for clean edges
      s_nxt.up = pump_up_i & ~dso[STO_PUMP_DIS_BIT]; // [RULE7]
      s_nxt.dn = pump_dn_i & ~dso[STO_PUMP_DIS_BIT]; // [RULE7]
   end

   // State register
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign ctrl_o = s_r.ctrl;
   assign pump_up_o = s_r.up;
   assign pump_dn_o = s_r.dn;
endmodule
`default_nettype wire

//--- logic/sto_regs.sv
`default_nettype none
module sto_regs (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic cfg_clk_i,
   input wire logic cfg_ale_n_i,
   input wire logic cfg_data_i,
   output logic cfg_data_o,
   output logic cfg_data_oe_o,
   input wire sto_pkg::sto_cal_t cal_i,
   input wire logic pump_up_i,
   input wire logic pump_dn_i,
   output var sto_pkg::sto_ctrl_t ctrl_o,
   output logic pump_up_o,
   output logic pump_dn_o
);
   import sto_pkg::*;

   // ==========================================================
   // Declarations
   sto_ser_s_t s_r;
   sto_ser_s_t s_nxt;
   sto_ctrl_t ctrl;
   logic clk_rise;
   logic [7:0] sh_in;

   // ==========================================================
   // Helper functions

   // Mask of writable bits for an address; zero means nothing is stored
   function automatic logic [7:0] wr_mask(input logic [6:0] a);
      logic [7:0] m;
      m = 8'h00;
      unique case (a)
         STO_ADDR_PRESCALER_SETTINGS: m = STO_MASK_PRESCALER;
         STO_ADDR_TEST_LF_PUMP_OVR: m = STO_MASK_LF_PUMP;
         STO_ADDR_TEST_PUMP_DIS_OSC_OVR: m = STO_MASK_DIS_OSC;
         STO_ADDR_TEST_LOOP_BW_SCALING: m = STO_MASK_BW;
         STO_ADDR_TEST_LOOP_BREAK_DAC: m = STO_MASK_BREAK;
         default: m = 8'h00;
      endcase
      return m;
   endfunction

   // Store one written byte; status and unmapped addresses are untouched
   function automatic sto_cfg_t cfg_write(input sto_cfg_t c,
                                          input logic [6:0] a,
                                          input logic [7:0] d);
      sto_cfg_t r;
      logic [7:0] v;
      r = c;
      v = d & wr_mask(a); // [RULE14]
      unique case (a)
         STO_ADDR_PRESCALER_SETTINGS: r.prescaler_settings = v;
         STO_ADDR_TEST_LF_PUMP_OVR: r.test_loopfilter_chargepump_override = v;
         STO_ADDR_TEST_PUMP_DIS_OSC_OVR: begin
            r.test_chargepump_disable_osc_array_override_en = v;
         end
         STO_ADDR_TEST_LOOP_BW_SCALING: r.test_loop_bandwidth_scaling = v;
         STO_ADDR_TEST_LOOP_BREAK_DAC: r.test_loop_break_cal_dac = v;
         default: r = c; // [RULE14]
      endcase
      return r;
   endfunction

   // Read mux; unused bits and unmapped addresses return zero
   function automatic logic [7:0] rd_data(input sto_cfg_t c,
                                          input sto_ctrl_t k,
                                          input logic [6:0] a);
      logic [7:0] d;
      d = 8'h00;
      unique case (a)
         STO_ADDR_PRESCALER_SETTINGS: d = c.prescaler_settings;
         STO_ADDR_TEST_LF_PUMP_OVR: d = c.test_loopfilter_chargepump_override;
         STO_ADDR_TEST_PUMP_DIS_OSC_OVR: begin
            d = c.test_chargepump_disable_osc_array_override_en;
         end
         STO_ADDR_TEST_LOOP_BW_SCALING: d = c.test_loop_bandwidth_scaling;
         STO_ADDR_TEST_LOOP_BREAK_DAC: d = c.test_loop_break_cal_dac;
         STO_ADDR_STATUS_PUMP_CURRENT: begin
            d = {3'h0, k.applied_pump_current}; // [RULE11]
         end
         STO_ADDR_STATUS_CAL_DAC: begin
            d = {4'h0, k.applied_cal_dac}; // [RULE12]
         end
         STO_ADDR_STATUS_OSC_ARRAY: begin
            d = {4'h0, k.applied_osc_array}; // [RULE13]
         end
         default: d = 8'h00; // [RULE14]
      endcase
      return d & (wr_mask(a) | status_mask(a)); // [RULE14]
   endfunction

   // Bits of a status register that carry live state
   function automatic logic [7:0] status_mask(input logic [6:0] a);
      logic [7:0] m;
      m = 8'h00;
      unique case (a)
         STO_ADDR_STATUS_PUMP_CURRENT: m = 8'h1F;
         STO_ADDR_STATUS_CAL_DAC: m = 8'h0F;
         STO_ADDR_STATUS_OSC_ARRAY: m = 8'h0F;
         default: m = 8'h00;
      endcase
      return m;
   endfunction

   // ==========================================================
   // Serial configuration port

   // Serial pins are taken as synchronous; the bus clock must be slow
   // enough that every level lasts at least two system clocks
   assign clk_rise = cfg_clk_i & ~s_r.clk_d;
   assign sh_in = {s_r.sh[6:0], cfg_data_i};

   // Frame: address byte (7 address bits then write flag, MSB first)
   // while the latch enable is low, then one data byte while it is high
   always_comb begin
      s_nxt = s_r;
      s_nxt.clk_d = cfg_clk_i;
      unique case (s_r.st)
         SER_IDLE: begin
            s_nxt.oe = 1'b0;
            if (!cfg_ale_n_i) begin
               s_nxt.st = SER_ADDR;
               s_nxt.cnt = 4'h0;
            end
         end
         SER_ADDR: begin
            if (cfg_ale_n_i) begin
               // Short address phase: drop the frame
               s_nxt.st = SER_IDLE;
            end else if (clk_rise) begin
               s_nxt.sh = sh_in;
               s_nxt.cnt = s_r.cnt + 4'h1;
               if (s_r.cnt == STO_LAST_BIT) begin
                  s_nxt.addr = sh_in[7:1];
                  s_nxt.wr = sh_in[0];
                  s_nxt.st = SER_GAP;
               end
            end
         end
         SER_GAP: begin
            // Wait for the latch enable to rise before the data byte
            if (cfg_ale_n_i) begin
               s_nxt.cnt = 4'h0;
               if (s_r.wr) begin
                  s_nxt.st = SER_WDATA;
               end else begin
                  // Read data is sampled once here, then shifted out
                  s_nxt.st = SER_RDATA;
                  s_nxt.sh = rd_data(s_r.cfg, ctrl, s_r.addr);
                  s_nxt.oe = 1'b1;
               end
            end
         end
         SER_WDATA: begin
            if (!cfg_ale_n_i) begin
               // New address phase aborts a partial data byte
               s_nxt.st = SER_ADDR;
               s_nxt.cnt = 4'h0;
            end else if (clk_rise) begin
               s_nxt.sh = sh_in;
               s_nxt.cnt = s_r.cnt + 4'h1;
               if (s_r.cnt == STO_LAST_BIT) begin
                  s_nxt.cfg = cfg_write(s_r.cfg, s_r.addr, sh_in);
                  s_nxt.st = SER_IDLE;
               end
            end
         end
         SER_RDATA: begin
            if (!cfg_ale_n_i) begin
               s_nxt.st = SER_ADDR;
               s_nxt.cnt = 4'h0;
               s_nxt.oe = 1'b0;
            end else if (clk_rise) begin
               // Host sampled this bit on the rising edge; present next
               s_nxt.sh = {s_r.sh[6:0], 1'b0};
               s_nxt.cnt = s_r.cnt + 4'h1;
               if (s_r.cnt == STO_LAST_BIT) begin
                  s_nxt.oe = 1'b0;
                  s_nxt.st = SER_IDLE;
               end
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_r <= STO_SER_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Data pin is the shift register MSB ANDed with the output enable flop
   assign cfg_data_o = s_r.oe & s_r.sh[7];
   assign cfg_data_oe_o = s_r.oe;

   // ==========================================================
   // Override selection and applied values
   sto_apply_sel u_apply_sel (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .cfg_i(s_r.cfg),
      .cal_i(cal_i),
      .pump_up_i(pump_up_i),
      .pump_dn_i(pump_dn_i),
      .ctrl_o(ctrl),
      .pump_up_o(pump_up_o),
      .pump_dn_o(pump_dn_o)
   );

   assign ctrl_o = ctrl;
endmodule
`default_nettype wire

//--- tb/sto_regs_properties.sv
`default_nettype none
module sto_regs_properties (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic cfg_ale_n_i,
   input wire logic cfg_data_o,
   input wire logic cfg_data_oe_o,
   input wire sto_pkg::sto_cal_t cal_i,
   input wire logic pump_up_i,
   input wire logic pump_dn_i,
   input wire sto_pkg::sto_ctrl_t ctrl_o,
   input wire logic pump_up_o,
   input wire logic pump_dn_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import sto_pkg::*;
   // =============================================
   // Expected fractions, packed as num then den
   localparam logic [5:0] SW [4] = '{6'h09, 6'h13, 6'h3B, 6'h2B};
   localparam logic [5:0] CU [4] = '{6'h09, 6'h13, 6'h0A, 6'h15};
   logic [5:0] sw_exp;
   logic [5:0] cu_exp;
   assign sw_exp = SW[ctrl_o.swing_code];
   assign cu_exp = CU[ctrl_o.current_code];
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   // =============================================
   // Two samples of disable cover either gating stage
   pump_gate_a: assert property (
      ctrl_o.pump_pulse_disable && $past(ctrl_o.pump_pulse_disable)
      |-> !pump_up_o && !pump_dn_o)
      else $error("pump pulse passed while disabled");
   pump_pass_a: assert property (
      !$past(sys_rst_i) && !ctrl_o.pump_pulse_disable &&
      !$past(ctrl_o.pump_pulse_disable) |-> pump_up_o == $past(pump_up_i)
      && pump_dn_o == $past(pump_dn_i))
      else $error("pump pulse not passed one clock later");
   node_ground_a: assert property (
      !$past(sys_rst_i) |-> ctrl_o.pump_output_node_grounded ==
      !(ctrl_o.loop_testpoint_a_sel || ctrl_o.loop_testpoint_b_sel))
      else $error("pump node grounding wrong");
   swing_frac_a: assert property (
      !$past(sys_rst_i) |-> ctrl_o.swing == sw_exp)
      else $error("swing fraction wrong");
   current_frac_a: assert property (
      !$past(sys_rst_i) |-> ctrl_o.current == cu_exp)
      else $error("current fraction wrong");
   dac_closed_a: assert property (
      !$past(sys_rst_i) && !ctrl_o.loop_open
      |-> ctrl_o.applied_cal_dac == $past(cal_i.cal_dac))
      else $error("closed loop dac not calibrated value");
   reset_state_a: assert property (
      $fell(sys_rst_i) |=> ctrl_o.loop_bandwidth_scaling == 6'h25 &&
      !ctrl_o.loop_open && ctrl_o.applied_osc_array == $past(cal_i.osc_array))
      else $error("controls wrong after reset");
   read_idle_a: assert property (
      !cfg_data_oe_o |-> !cfg_data_o)
      else $error("read data not low while pin released");
   // Only a read data byte may drive the pin, never an address phase
   addr_phase_pin_a: assert property (
      !$past(sys_rst_i) && !$past(cfg_ale_n_i) |-> !cfg_data_oe_o)
      else $error("data pin driven during address phase");
   cover property (ctrl_o.pump_pulse_disable && pump_up_i);
   cover property (ctrl_o.loop_open);
   cover property ($rose(cfg_data_oe_o));
endmodule
`default_nettype wire

//--- tb/sto_host_model.sv
`default_nettype none
module sto_host_model (
   input wire logic clock_i,
   input wire logic cfg_data_o,
   input wire logic cfg_data_oe_o,
   output logic cfg_clk_o,
   output logic cfg_ale_n_o,
   output logic cfg_data_w_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic drv = 1'b1;
   logic bit_v = 1'b0;
   logic tgl = 1'b0;
   // Released pin shows a moving pattern, never a held value
   assign cfg_data_w_o = drv ? bit_v : cfg_data_oe_o ? cfg_data_o : tgl;
   always @(negedge clock_i) tgl <= ~tgl;
   initial begin
      cfg_clk_o = 1'b0;
      cfg_ale_n_o = 1'b1;
   end
   // Each serial level lasts four clocks, above the two needed
   task automatic tick();
      repeat (4) @(negedge clock_i);
      cfg_clk_o = 1'b1;
      repeat (4) @(negedge clock_i);
      cfg_clk_o = 1'b0;
   endtask
   // One frame: address byte with flag, then one data byte
   task automatic frame(input logic [6:0] a, input logic w,
         input logic [7:0] d, output logic [7:0] q);
      cfg_ale_n_o = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         bit_v = i > 0 ? a[i - 1] : w;
         tick();
      end
      cfg_ale_n_o = 1'b1;
      drv = w;
      for (int i = 7; i >= 0; i--) begin
         bit_v = d[i];
         repeat (4) @(negedge clock_i);
         q[i] = cfg_data_w_o;
         cfg_clk_o = 1'b1;
         repeat (4) @(negedge clock_i);
         cfg_clk_o = 1'b0;
      end
      drv = 1'b1;
      repeat (4) @(negedge clock_i);
   endtask
endmodule
`default_nettype wire

//--- tb/synth_test_override_regs_test.sv
`default_nettype none
module synth_test_override_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   import sto_pkg::*;
   logic clock_i, sys_rst_i, cfg_clk, cfg_ale_n, cfg_dw;
   logic up = 1'b0;
   logic dn = 1'b0;
   logic cfg_data_o, cfg_data_oe_o, pump_up_o, pump_dn_o;
   sto_cal_t cal;
   sto_ctrl_t ctrl_o;
   logic [7:0] m [128];
   logic [7:0] q;
   logic [6:0] a;
   logic [6:0] adr [9] = '{7'h1C, 7'h40, 7'h41, 7'h42, 7'h43, 7'h44,
      7'h45, 7'h46, 7'h47};
   logic [5:0] sw [4] = '{6'h09, 6'h13, 6'h3B, 6'h2B};
   logic [5:0] cu [4] = '{6'h09, 6'h13, 6'h0A, 6'h15};
   int fail_count = 0;
   int checks = 0;
   int cyc = 0;
   sto_regs dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .cfg_clk_i(cfg_clk), .cfg_ale_n_i(cfg_ale_n), .cfg_data_i(cfg_dw),
      .cfg_data_o(cfg_data_o), .cfg_data_oe_o(cfg_data_oe_o), .cal_i(cal),
      .pump_up_i(up), .pump_dn_i(dn), .ctrl_o(ctrl_o),
      .pump_up_o(pump_up_o), .pump_dn_o(pump_dn_o));
   sto_host_model host (.clock_i(clock_i), .cfg_data_o(cfg_data_o),
      .cfg_data_oe_o(cfg_data_oe_o), .cfg_clk_o(cfg_clk),
      .cfg_ale_n_o(cfg_ale_n), .cfg_data_w_o(cfg_dw));
   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end
   // Random pump levels redrawn every clock, so pulses are often one clock long, for the gating checks
   always @(negedge clock_i) begin
      up <= 1'($urandom);
      dn <= 1'($urandom);
   end
   // Cut a hang short well past the expected run length
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         report_and_stop();
      end
   end
   // =============================================
   // Reference model
   function automatic logic [7:0] msk(input logic [6:0] r);
      case (r)
         7'h1C: return 8'hFC;
         7'h40: return 8'hFF;
         7'h41, 7'h42: return 8'h3F;
         7'h43: return 8'h1F;
         default: return 8'h00;
      endcase
   endfunction
   function automatic sto_ctrl_t exp_ctrl();
      sto_ctrl_t x;
      logic [7:0] p, t6, t5, t3;
      p = m[7'h1C];
      t6 = m[7'h40];
      t5 = m[7'h41];
      t3 = m[7'h43];
      x.swing_code = p[7:6];
      x.swing = sw[p[7:6]];
      x.current_code = p[5:4];
      x.current = cu[p[5:4]];
      x.if_strip_from_pin = p[3];
      x.if_front_to_pin = p[2];
      x.loop_testpoint_a_sel = t6[7];
      x.loop_testpoint_b_sel = t6[6];
      x.pump_output_node_grounded = !(t6[7] | t6[6]);
      x.applied_pump_current = t6[5] ? t6[4:0] : cal.pump_current;
      x.pump_pulse_disable = t5[5];
      x.applied_osc_array = t5[4] ? t5[3:0] : cal.osc_array;
      x.loop_bandwidth_scaling = m[7'h42][5:0];
      x.loop_open = t3[4];
      x.applied_cal_dac = t3[4] ? t3[3:0] : cal.cal_dac;
      return x;
   endfunction
   function automatic logic [7:0] exp_rd(input logic [6:0] r);
      sto_ctrl_t x;
      x = exp_ctrl();
      case (r)
         7'h44: return {3'h0, x.applied_pump_current};
         7'h45: return {4'h0, x.applied_cal_dac};
         7'h46: return {4'h0, x.applied_osc_array};
         default: return m[r];
      endcase
   endfunction
   // =============================================
   // Checking and bus access
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got,
            exp);
      end
   endtask
   task automatic wr(input logic [6:0] r, input logic [7:0] d);
      host.frame(r, 1'b1, d, q);
      m[r] = d & msk(r);
   endtask
   task automatic rd_chk(input logic [6:0] r);
      host.frame(r, 1'b0, 8'h00, q);
      cmp(q, exp_rd(r));
   endtask
   task automatic report_and_stop();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // =============================================
   // Main sequence
   initial begin
      void'($urandom(64));
      sys_rst_i = 1'b1;
      cal = '0;
      m = '{default: 8'h00};
      m[7'h40] = 8'h10;
      m[7'h41] = 8'h08;
      m[7'h42] = 8'h25;
      m[7'h43] = 8'h04;
      repeat (2) @(negedge clock_i);
      sys_rst_i = 1'b0;
      repeat (2) @(negedge clock_i);
      // Reset values, status places and an unmapped place
      foreach (adr[i]) rd_chk(adr[i]);
      cmp(ctrl_o, exp_ctrl());
      // Every swing and current code, unused bits written high
      for (int c = 0; c < 4; c++) begin
         wr(7'h1C, {c[1:0], c[1:0], 4'hF});
         cmp(ctrl_o, exp_ctrl());
      end
      wr(7'h42, 8'h3F);
      // Random writes everywhere with moving calibrated values
      for (int n = 0; n < 60; n++) begin
         cal = 13'($urandom);
         a = adr[$urandom_range(8)];
         wr(a, 8'($urandom));
         cmp(ctrl_o, exp_ctrl());
         rd_chk(a);
      end
      report_and_stop();
   end
endmodule
bind sto_regs sto_regs_properties chk (.clock_i(clock_i),
   .sys_rst_i(sys_rst_i), .cfg_ale_n_i(cfg_ale_n_i), .cfg_data_o(cfg_data_o),
   .cfg_data_oe_o(cfg_data_oe_o), .cal_i(cal_i), .pump_up_i(pump_up_i),
   .pump_dn_i(pump_dn_i), .ctrl_o(ctrl_o), .pump_up_o(pump_up_o),
   .pump_dn_o(pump_dn_o));
`default_nettype wire
